// *** rtl/arb_defs.svh ***
// constants for the data bus arbiter
`ifndef ARB_DEFS_SVH
`define ARB_DEFS_SVH
`define ARB_NUM_LEVELS 10
`define ARB_LVL_CB_URGENT 0
`define ARB_LVL_PCI_RD_SNOOPED 1
`define ARB_LVL_CPU_PRIO 2
`define ARB_LVL_WB_URGENT 3
`define ARB_LVL_CB_MEDIUM 4
`define ARB_LVL_NORMAL 5
`define ARB_LVL_PCI_RD_UNSNOOPED 6
`define ARB_LVL_CB_LOW 7
`define ARB_LVL_WB_LOW 8
`define ARB_LVL_PREFETCH 9
`define ARB_NUM_WBUF 2
`define ARB_LINE_BYTES 32
`define ARB_GRANT_RESET 10'h000
`endif

// *** rtl/arb_pkg.sv ***
// types for the data bus arbiter
package arb_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} arb_state_e;
	typedef logic [9:0] level_vec_t;
endpackage : arb_pkg

// *** rtl/arb_req_if.sv ***
// request and grant vectors between the classifier and the arbiter core
`timescale 1ns/10ps
interface arb_req_if;
	logic [9:0] level_req;
	logic [9:0] level_grant;
	modport cls (output level_req, input level_grant);
	modport arb (input level_req, output level_grant);
endinterface : arb_req_if

// *** rtl/arb_pick.sv ***
// fixed-priority pick of one level, lowest index first
`timescale 1ns/10ps
`include "arb_defs.svh"
module arb_pick import arb_pkg::*; #(
	parameter int N = `ARB_NUM_LEVELS
) (
	input wire logic [N-1:0] req,
	output logic [N-1:0] onehot
);
	logic [N-1:0] blocked;
	assign blocked[0] = 1'b0;
	genvar i;
	generate
		for (i = 1; i < N; i++) begin : g_chain
			assign blocked[i] = blocked[i-1] | req[i-1];
		end
	endgenerate
	assign onehot = req & ~blocked;
endmodule : arb_pick

// *** rtl/cpu_mem_data_arbiter.sv ***
// processor/memory data bus arbiter with ten fixed urgency levels
//
// Functional notes
// - the PCI bus itself is arbitrated outside; this block only shares the data bus.
// - processor-to-PCI transfers come in one ordered queue and are granted in issue order.
// - with snooping on, PCI memory snoops come in one ordered queue and keep their order.
// - level 1 is the urgent copyback buffer flush from a hit, castout clash or ECC burst hit.
// - level 2 is a PCI memory read whose snoop has completed, or any PCI memory read with snooping off.
// - level 3 is priority processor or L2 traffic (snoop-hit copyback, CPU read, fast castout).
// - level 4 is the urgent write buffer flush on a read hit, full buffers or CPU hit.
// - level 5 is the medium copyback flush on a CPU hit or a full copyback buffer.
// - level 6 is normal traffic: CPU memory writes, write-snoop copybacks, CPU to PCI, fills.
// - level 7 is a PCI memory read whose snoop is still outstanding.
// - level 8 is the non-urgent copyback flush, served only when levels 1 to 7 are idle.
// - level 9 is the non-urgent write buffer flush, served only when all above are idle.
// - level 10, the lowest, is the speculative prefetch into the read buffer.
// - two write buffers of one 32-byte line each alternate between filling and flushing.
`timescale 1ns/10ps
`include "arb_defs.svh"
module cpu_mem_data_arbiter import arb_pkg::*; (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	// copyback buffer
	input wire logic CB_VALID,
	input wire logic CB_PCI_HIT,
	input wire logic CB_CASTOUT_PCI_SAME,
	input wire logic CB_CPU_HIT,
	input wire logic CB_FULL_NEW_DATA,
	input wire logic CB_FILL_REQ,
	// write buffers, the four vectors carry one bit per buffer
	input wire logic [`ARB_NUM_WBUF-1:0] WB_READY,
	input wire logic [`ARB_NUM_WBUF-1:0] WB_PCI_RD_HIT,
	input wire logic [`ARB_NUM_WBUF-1:0] WB_CPU_HIT,
	input wire logic [`ARB_NUM_WBUF-1:0] WB_UNSNOOPED_HIT,
	input wire logic WB_FULL_NEW_WRITE,
	input wire logic L2_CASTOUT,
	input wire logic CPU_ECC_BURST_WR,
	// PCI read of memory (ordered snoop queue head)
	input wire logic PCI_RD_REQ,
	input wire logic PCI_RD_SNOOP_DONE,
	input wire logic SNOOP_EN,
	input wire logic PREFETCH_REQ,
	// processor and L2
	input wire logic CPU_PRIO_REQ,
	input wire logic CPU_NORMAL_REQ,
	input wire logic CPU_PCI_REQ,
	// transfer end strobe from the data path
	input wire logic XFER_DONE,
	output logic [`ARB_NUM_LEVELS-1:0] GRANT, // data bus only, no PCI bus pins
	output logic [`ARB_NUM_WBUF-1:0] WB_FLUSH_GRANT,
	output logic BUSY
);
	arb_req_if rif ();
	arb_state_e state_q, state_d;
	level_vec_t grant_q, grant_d;
	logic [`ARB_NUM_WBUF-1:0] wbsel_q, wbsel_d;
	logic wb_oldest_q;

	// unsnooped write buffer hits only matter with snooping on
	logic wb_unsn;
	assign wb_unsn = SNOOP_EN & (|(WB_UNSNOOPED_HIT & WB_READY));
	logic cb_urgent;
	assign cb_urgent = CB_VALID & (CB_PCI_HIT | CB_CASTOUT_PCI_SAME
		| (wb_unsn & (L2_CASTOUT | CPU_ECC_BURST_WR)));
	logic cb_medium;
	assign cb_medium = CB_VALID & ~cb_urgent & (CB_CPU_HIT | CB_FULL_NEW_DATA);
	logic cb_low;
	assign cb_low = CB_VALID & ~cb_urgent & ~cb_medium;

	logic [`ARB_NUM_WBUF-1:0] wb_urg_vec;
	assign wb_urg_vec = WB_READY & (WB_PCI_RD_HIT | WB_CPU_HIT
		| {`ARB_NUM_WBUF{WB_FULL_NEW_WRITE}});
	logic wb_urgent;
	assign wb_urgent = |wb_urg_vec;
	logic wb_low;
	assign wb_low = (|WB_READY) & ~wb_urgent;

	// snoop state decides level 2 versus level 7 each cycle
	logic rd_done;
	assign rd_done = PCI_RD_SNOOP_DONE | ~SNOOP_EN;

	logic [`ARB_NUM_LEVELS-1:0] req;
	assign req[`ARB_LVL_CB_URGENT] = cb_urgent;
	assign req[`ARB_LVL_PCI_RD_SNOOPED] = PCI_RD_REQ & rd_done;
	assign req[`ARB_LVL_CPU_PRIO] = CPU_PRIO_REQ;
	assign req[`ARB_LVL_WB_URGENT] = wb_urgent;
	assign req[`ARB_LVL_CB_MEDIUM] = cb_medium;
	assign req[`ARB_LVL_NORMAL] = CPU_NORMAL_REQ | CPU_PCI_REQ | CB_FILL_REQ;
	assign req[`ARB_LVL_PCI_RD_UNSNOOPED] = PCI_RD_REQ & ~rd_done;
	assign req[`ARB_LVL_CB_LOW] = cb_low;
	assign req[`ARB_LVL_WB_LOW] = wb_low;
	assign req[`ARB_LVL_PREFETCH] = PREFETCH_REQ;
	assign rif.level_req = req;

	arb_pick #(.N(`ARB_NUM_LEVELS)) u_pick (
		.req(rif.level_req),
		.onehot(rif.level_grant)
	);

	// choose which write buffer flushes: urgent one first, else the older fill
	function automatic logic [1:0] pick_wb(input logic [1:0] cand, input logic oldest);
		if (cand[oldest])
			pick_wb = oldest ? 2'h2 : 2'h1;
		else if (cand[~oldest])
			pick_wb = oldest ? 2'h1 : 2'h2;
		else
			pick_wb = 2'h0;
	endfunction : pick_wb

	logic wb_granted;
	assign wb_granted = rif.level_grant[`ARB_LVL_WB_URGENT] | rif.level_grant[`ARB_LVL_WB_LOW];
	logic [1:0] wb_choice;
	assign wb_choice = pick_wb(wb_urgent ? wb_urg_vec : WB_READY, wb_oldest_q);
	logic take;
	assign take = (state_q == ST_IDLE) && (|req);

	// a grant is held until the data path reports the end; no preemption
	always_comb begin
		state_d = state_q;
		grant_d = grant_q;
		wbsel_d = wbsel_q;
		case (state_q)
			ST_IDLE: begin
				if (take) begin
					state_d = ST_BUSY;
					grant_d = rif.level_grant;
					wbsel_d = wb_granted ? wb_choice : 2'h0;
				end
			end
			ST_BUSY: begin
				if (XFER_DONE) begin
					state_d = ST_IDLE;
					grant_d = `ARB_GRANT_RESET;
					wbsel_d = 2'h0;
				end
			end
			default: begin
				state_d = ST_IDLE;
				grant_d = `ARB_GRANT_RESET;
				wbsel_d = 2'h0;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			grant_q <= `ARB_GRANT_RESET;
			wbsel_q <= 2'h0;
			wb_oldest_q <= 1'b0;
		end else if (CLK_EN) begin
			state_q <= state_d;
			grant_q <= grant_d;
			wbsel_q <= wbsel_d;
			if (state_q == ST_BUSY && XFER_DONE && |wbsel_q)
				wb_oldest_q <= wbsel_q[0];
		end
	end

	// ordered queues outside order; one request line each here
	assign GRANT = grant_q;
	assign WB_FLUSH_GRANT = wbsel_q;
	assign BUSY = state_q[1];

	// assertions
	property p_onehot;
		@(posedge CLOCK) disable iff (!RST_N)
		$onehot0(GRANT);
	endproperty
	a_onehot: assert property (p_onehot) else $error("more than one grant");
	c_cb: cover property (@(posedge CLOCK) disable iff (!RST_N) GRANT[0]);

	property p_hold;
		@(posedge CLOCK) disable iff (!RST_N)
		(BUSY && !XFER_DONE && CLK_EN) |=> $stable(GRANT);
	endproperty
	a_hold: assert property (p_hold) else $error("grant changed mid transfer");

	property p_release;
		@(posedge CLOCK) disable iff (!RST_N)
		(BUSY && XFER_DONE && CLK_EN) |=> (GRANT == `ARB_GRANT_RESET) && !BUSY;
	endproperty
	a_release: assert property (p_release) else $error("grant not released");

	property p_top;
		@(posedge CLOCK) disable iff (!RST_N)
		(!BUSY && CLK_EN && cb_urgent) |=> GRANT[`ARB_LVL_CB_URGENT];
	endproperty
	a_top: assert property (p_top) else $error("urgent copyback not first");

	property p_rd_snooped;
		@(posedge CLOCK) disable iff (!RST_N)
		(!BUSY && CLK_EN && PCI_RD_REQ && rd_done && !cb_urgent) |=> GRANT[1];
	endproperty
	a_rd_snooped: assert property (p_rd_snooped) else $error("snooped read lost");

	property p_rd_unsnooped;
		@(posedge CLOCK) disable iff (!RST_N)
		// only the taking cycle counts; requests may change while the grant is held
		(GRANT[`ARB_LVL_PCI_RD_UNSNOOPED] && !$past(BUSY)) |->
			$past(SNOOP_EN) && !$past(PCI_RD_SNOOP_DONE);
	endproperty
	a_rd_unsnooped: assert property (p_rd_unsnooped) else $error("bad level 7");

	property p_prefetch;
		@(posedge CLOCK) disable iff (!RST_N)
		(GRANT[`ARB_LVL_PREFETCH] && !$past(BUSY)) |-> $past(req[8:0]) == 9'h000;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("prefetch won over others");

	property p_wb;
		@(posedge CLOCK) disable iff (!RST_N)
		(GRANT[3] || GRANT[8]) |-> $onehot(WB_FLUSH_GRANT);
	endproperty
	a_wb: assert property (p_wb) else $error("write buffer flush without one buffer");

	property p_cb_low;
		@(posedge CLOCK) disable iff (!RST_N)
		(GRANT[`ARB_LVL_CB_LOW] && !$past(BUSY)) |-> $past(req[6:0]) == 7'h00;
	endproperty
	a_cb_low: assert property (p_cb_low) else $error("low copyback jumped ahead");

	c_prio: cover property (@(posedge CLOCK) GRANT[2]);
	c_wb: cover property (@(posedge CLOCK) GRANT[3] ##[1:20] GRANT[8]);
	c_pf: cover property (@(posedge CLOCK) GRANT[9]);
endmodule : cpu_mem_data_arbiter

// *** dv/data_path_model.sv ***
// behavioural data path that ends each granted transfer after a set hold
`timescale 1ns/10ps
module data_path_model (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic BUSY,
	input wire logic [3:0] HOLD,
	output logic XFER_DONE
);
	int cnt = 0;
	initial XFER_DONE = 1'b0;
	// hold 0 answers at once, larger holds stand for a slow burst
	always @(posedge CLOCK) begin
		#1;
		if (!RST_N || !BUSY || XFER_DONE) begin
			cnt = 0;
			XFER_DONE = 1'b0;
		end else begin
			cnt++;
			XFER_DONE = (cnt > HOLD);
		end
	end
endmodule : data_path_model

// *** dv/cpu_memory_data_bus_arbiter_tb_top.sv ***
// self-checking bench for the data bus arbiter
`timescale 1ns/10ps
module cpu_memory_data_bus_arbiter_tb_top import arb_pkg::*;;
	logic CLOCK = 1'b0;
	logic RST_N = 1'b0;
	logic [23:0] rq = 24'h000000;
	logic [3:0] hold = 4'h0;
	logic en = 1'b1;
	logic xfer_done, busy;
	level_vec_t grant;
	logic [1:0] wbg;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	// one cause per entry; bit order follows the port list below
	localparam logic [23:0] CAUSE [19] = '{24'hC00000, 24'hA00000, 24'h822041, 24'h812041,
		24'h00E000, 24'h008000, 24'h000800, 24'h000050, 24'h000088, 24'h0001C0, 24'h900000,
		24'h880000, 24'h000400, 24'h000200, 24'h040000, 24'h00A000, 24'h800000, 24'h000040,
		24'h001000};
	localparam int LVL [19] = '{0, 0, 0, 0, 1, 1, 2, 3, 3, 3, 4, 4, 5, 5, 5, 6, 7, 8, 9};
	always #10 CLOCK = ~CLOCK;
	cpu_mem_data_arbiter i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(en), .CB_VALID(rq[23]),
		.CB_PCI_HIT(rq[22]), .CB_CASTOUT_PCI_SAME(rq[21]), .CB_CPU_HIT(rq[20]),
		.CB_FULL_NEW_DATA(rq[19]), .CB_FILL_REQ(rq[18]), .L2_CASTOUT(rq[17]),
		.CPU_ECC_BURST_WR(rq[16]), .PCI_RD_REQ(rq[15]), .PCI_RD_SNOOP_DONE(rq[14]),
		.SNOOP_EN(rq[13]), .PREFETCH_REQ(rq[12]), .CPU_PRIO_REQ(rq[11]), .CPU_NORMAL_REQ(rq[10]),
		.CPU_PCI_REQ(rq[9]), .WB_FULL_NEW_WRITE(rq[8]), .WB_READY(rq[7:6]),
		.WB_PCI_RD_HIT(rq[5:4]), .WB_CPU_HIT(rq[3:2]), .WB_UNSNOOPED_HIT(rq[1:0]),
		.XFER_DONE(xfer_done), .GRANT(grant), .WB_FLUSH_GRANT(wbg), .BUSY(busy));
	data_path_model i_dp (.CLOCK(CLOCK), .RST_N(RST_N), .BUSY(busy), .HOLD(hold),
		.XFER_DONE(xfer_done));
	task chk(input logic [9:0] s, input logic [9:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task tick();
		@(posedge CLOCK);
		#1;
	endtask : tick
	// bounded waits: a hung grant shows up as a mismatch, not a stall
	task take();
		for (int n = 0; n < 8 && busy !== 1'b1; n++) tick();
	endtask : take
	task idle();
		for (int n = 0; n < 20 && busy !== 1'b0; n++) tick();
	endtask : idle
	task one_cause(input int i, input logic [23:0] extra);
		rq = CAUSE[i] | extra;
		take();
		chk(grant, 10'h001 << LVL[i]);
		if ((LVL[i] == 3 || LVL[i] == 8) && CAUSE[i][7:6] inside {2'h1, 2'h2})
			chk({8'h00, wbg}, {8'h00, CAUSE[i][7:6]});
		rq = 24'h000000;
		idle();
	endtask : one_cause
	task no_preempt();
		hold = 4'h5;
		rq = 24'h001000;
		take();
		chk(grant, 10'h200);
		rq = 24'h00A800;
		repeat (3) begin
			tick();
			chk(grant, 10'h200);
		end
		rq = 24'h80E000;
		idle();
		take();
		chk(grant, 10'h002);
		rq = 24'h000000;
		idle();
		hold = 4'h0;
		$display("test no_preempt done");
	endtask : no_preempt
	// two non-urgent flushes with both buffers ready take turns
	task wb_alternate();
		logic [1:0] first;
		rq = 24'h0000C0;
		take();
		first = wbg;
		chk(grant, 10'h100);
		chk({9'h000, $onehot(wbg)}, 10'h001);
		idle();
		take();
		chk({8'h00, wbg}, {8'h00, ~first});
		rq = 24'h000000;
		idle();
		$display("test wb_alternate done");
	endtask : wb_alternate
	// with the clock enable low a pending request must not be taken
	task freeze();
		en = 1'b0;
		rq = 24'h000800;
		repeat (3) begin
			tick();
			chk({9'h000, busy}, 10'h000);
		end
		en = 1'b1;
		take();
		chk(grant, 10'h004);
		rq = 24'h000000;
		idle();
		$display("test freeze done");
	endtask : freeze
	// reset in the middle of a held grant must drop it at once
	task mid_reset();
		hold = 4'h5;
		rq = 24'h000800;
		take();
		chk(grant, 10'h004);
		RST_N = 1'b0;
		tick();
		chk(grant, 10'h000);
		chk({9'h000, busy}, 10'h000);
		RST_N = 1'b1;
		take();
		chk(grant, 10'h004);
		rq = 24'h000000;
		idle();
		hold = 4'h0;
		$display("test mid_reset done");
	endtask : mid_reset
	task reset_start();
		repeat (10) @(posedge CLOCK);
		#1;
		RST_N = 1'b1;
		chk(grant, 10'h000);
		chk({8'h00, wbg}, 10'h000);
		chk({9'h000, busy}, 10'h000);
		$display("test reset_start done");
	endtask : reset_start
	// alone, then racing the prefetch, which must lose to every other cause
	task all_causes();
		for (int i = 0; i < 19; i++) begin
			one_cause(i, 24'h000000);
			one_cause(i, 24'h001000);
		end
		$display("test causes done");
	endtask : all_causes
	task finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		reset_start();
		all_causes();
		no_preempt();
		wb_alternate();
		freeze();
		mid_reset();
		finish_test();
	end
endmodule : cpu_memory_data_bus_arbiter_tb_top
